// ---- rtl/fcs_sequencer.sv ----
`timescale 1ns/100ps
// What this block does
// - Command writes count only while the key field holds 0011B.
// - Reset loads the key field with the disabling value 1100B.
// - Control register bits 3 to 0 read as 0000B.
// - Six command sequences are recognised in the CPU-driven modes.
// - Byte program takes address and data from the fourth write; one byte.
// - Byte program finishes within 40 us of its last write.
// - Sector erase clears the 4 kbyte region picked by upper address bits.
// - Sector erase is refused in the parallel programmer mode.
// - Sector erase finishes within 30 ms.
// - Chip erase clears the whole array to FFH in about 30 ms.
// - Bit 6 inverts on each flash read while busy, except protected parallel-mode reads, which return FFH; stable afterwards.
// - First toggle-bit read after a started operation returns 1.
// - No new sequence is taken while an operation runs.
// - Identification mode returns maker, macro, size and protect codes.
// - The size code for this 16 kbyte array is 03H.
// - Protect status reads FFH when off, anything else when on.
// - Identification exit returns reads to array contents.
// - Protection blocks parallel array reads and raises serial_lock_o in serial mode; commands are not blocked.
// - Only a completed chip erase clears read protection.
// - Setting read protection finishes within 40 us, toggling bit 6.
// - The array is 16384 bytes at 04000H-07EFFH plus the top page.
// - Byte program is AAH, 55H, A0H then data at the target.
// - Chip erase is AAH, 55H, 80H, AAH, 55H, 10H on unlock addresses.
module fcs_sequencer #(
	parameter int         ERASE_CYCLES = fcs_pkg::ERASE_CYC,
	parameter int         PROG_CYCLES  = fcs_pkg::PROG_CYC,
	parameter int         RPROT_CYCLES = fcs_pkg::RPROT_CYC,
	parameter logic [7:0] MAKER_CODE   = 8'h5A,  // Arbitrary value
	parameter logic [7:0] MACRO_CODE   = 8'h3C,  // Arbitrary value
	parameter logic [7:0] SIZE_CODE    = fcs_pkg::SIZE_CODE_16K
) (
	input  wire logic             ref_clk_i,
	input  wire logic             sys_rst_i,
	input  wire fcs_pkg::fcs_bus_s bus_i,
	input  wire logic [1:0]       prog_mode_i,
	output logic      [7:0]       rd_data_o,
	output logic                  busy_o,
	output logic                  id_mode_o,
	output logic                  read_protect_o,
	output logic                  serial_lock_o
);

	// ==========================================================
	// Address mapping
	function automatic logic in_flash(input logic [19:0] a);
		in_flash = ((a >= fcs_pkg::FLASH_LO_BASE) && (a <= fcs_pkg::FLASH_LO_LAST)) ||
		           (a >= fcs_pkg::FLASH_TOP_BASE);
	endfunction

	function automatic logic [13:0] array_index(input logic [19:0] a);
		logic [19:0] off;
		off = a - fcs_pkg::FLASH_LO_BASE;
		if (a >= fcs_pkg::FLASH_TOP_BASE) begin
			array_index = fcs_pkg::TOP_PAGE_INDEX | {6'h00, a[7:0]};
		end else begin
			array_index = off[13:0];
		end
	endfunction

	// ==========================================================
	// Storage and state
	logic [7:0]          mem [0:fcs_pkg::ARRAY_BYTES-1];
	fcs_pkg::fcs_state_e state_q;
	fcs_pkg::fcs_state_e state_d;
	logic [3:0]          key_q;
	logic [1:0]          op_q;
	logic [20:0]         cnt_q;
	logic [13:0]         walk_q;
	logic                walk_on_q;
	logic                sect_on_q;
	logic [7:0]          sect_base_q;
	logic                tog_q;
	logic                id_mode_q;
	logic                rp_q;
	logic [1:0]          mode_s1_q;
	logic [1:0]          mode_s2_q;
	logic [1:0]          mode_s3_q;
	logic [1:0]          mode_q;
	logic [7:0]          rd_data_q;
	logic                serial_lock_q;
	logic                busy_q;

	logic                cmd_wr;
	logic                hit_a;
	logic                hit_b;
	logic                start;
	logic [1:0]          start_op;
	logic                op_done;
	logic [19:0]         walk_addr;
	logic [13:0]         walk_last;

	// ==========================================================
	// Mode pins: three stages, a change counts when stages two and three agree
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			mode_s1_q <= fcs_pkg::MODE_CPU;
			mode_s2_q <= fcs_pkg::MODE_CPU;
			mode_s3_q <= fcs_pkg::MODE_CPU;
			mode_q    <= fcs_pkg::MODE_CPU;
		end else begin
			mode_s1_q <= prog_mode_i;
			mode_s2_q <= mode_s1_q;
			mode_s3_q <= mode_s2_q;
			if (mode_s2_q == mode_s3_q) begin
				mode_q <= mode_s3_q;
			end
		end
	end

	// ==========================================================
	// Control register
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			key_q <= fcs_pkg::KEY_RESET;
		end else if (bus_i.we && (bus_i.addr == fcs_pkg::CTRL_ADDR)) begin
			key_q <= bus_i.wdata[7:fcs_pkg::KEY_LSB];
		end
	end

	// ==========================================================
	// Command decode
	// Busy and a wrong key both make the write invisible to the sequencer
	assign cmd_wr = bus_i.we && in_flash(bus_i.addr) &&
	                (key_q == fcs_pkg::KEY_ENABLE) &&
	                (state_q != fcs_pkg::ST_BUSY);
	assign hit_a  = (bus_i.addr == fcs_pkg::UNLOCK_ADDR_A);
	assign hit_b  = (bus_i.addr == fcs_pkg::UNLOCK_ADDR_B);

	always_comb begin
		state_d  = state_q;
		start    = 1'b0;
		start_op = fcs_pkg::OP_PROGRAM;
		case (state_q)
			fcs_pkg::ST_IDLE: begin
				if (cmd_wr && hit_a && (bus_i.wdata == fcs_pkg::UNLOCK_DATA_A)) begin
					state_d = fcs_pkg::ST_UNL1;
				end
			end
			fcs_pkg::ST_UNL1: begin
				if (cmd_wr) begin
					state_d = (hit_b && (bus_i.wdata == fcs_pkg::UNLOCK_DATA_B)) ?
					          fcs_pkg::ST_UNL2 : fcs_pkg::ST_IDLE;
				end
			end
			fcs_pkg::ST_UNL2: begin
				if (cmd_wr) begin
					state_d = fcs_pkg::ST_IDLE;
					if (hit_a && (bus_i.wdata == fcs_pkg::CMD_PROGRAM)) begin
						state_d = fcs_pkg::ST_PROG;
					end else if (hit_a && (bus_i.wdata == fcs_pkg::CMD_EXTEND)) begin
						state_d = fcs_pkg::ST_EXT3;
					end
				end
			end
			fcs_pkg::ST_PROG: begin
				if (cmd_wr) begin
					state_d  = fcs_pkg::ST_BUSY;
					start    = 1'b1;
					start_op = fcs_pkg::OP_PROGRAM;
				end
			end
			fcs_pkg::ST_EXT3: begin
				if (cmd_wr) begin
					state_d = (hit_a && (bus_i.wdata == fcs_pkg::UNLOCK_DATA_A)) ?
					          fcs_pkg::ST_EXT4 : fcs_pkg::ST_IDLE;
				end
			end
			fcs_pkg::ST_EXT4: begin
				if (cmd_wr) begin
					state_d = (hit_b && (bus_i.wdata == fcs_pkg::UNLOCK_DATA_B)) ?
					          fcs_pkg::ST_EXT5 : fcs_pkg::ST_IDLE;
				end
			end
			fcs_pkg::ST_EXT5: begin
				if (cmd_wr) begin
					state_d = fcs_pkg::ST_IDLE;
					if (hit_a && (bus_i.wdata == fcs_pkg::CMD_CHIP_ERASE)) begin
						state_d  = fcs_pkg::ST_BUSY;
						start    = 1'b1;
						start_op = fcs_pkg::OP_CHIP_ERASE;
					end else if ((bus_i.wdata == fcs_pkg::CMD_SECT_ERASE) &&
					             (mode_q != fcs_pkg::MODE_PARALLEL)) begin
						state_d  = fcs_pkg::ST_BUSY;
						start    = 1'b1;
						start_op = fcs_pkg::OP_SECT_ERASE;
					end else if (hit_a && (bus_i.wdata == fcs_pkg::CMD_READ_PROT)) begin
						state_d  = fcs_pkg::ST_BUSY;
						start    = 1'b1;
						start_op = fcs_pkg::OP_READ_PROT;
					end
				end
			end
			fcs_pkg::ST_BUSY: begin
				if (op_done) begin
					state_d = fcs_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = fcs_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state_q <= fcs_pkg::ST_IDLE;
			op_q    <= fcs_pkg::OP_PROGRAM;
		end else begin
			state_q <= state_d;
			if (start) begin
				op_q <= start_op;
			end
		end
	end

	// ==========================================================
	// Identification mode
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			id_mode_q <= 1'b0;
		end else if ((state_q == fcs_pkg::ST_UNL2) && cmd_wr && hit_a) begin
			if (bus_i.wdata == fcs_pkg::CMD_ID_ENTRY) begin
				id_mode_q <= 1'b1;
			end else if (bus_i.wdata == fcs_pkg::CMD_ID_EXIT) begin
				id_mode_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Operation timer
	// The timer fixes the minimum duration; busy also waits until the erase walk has ended
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			cnt_q <= 21'h0_0000;
		end else if (start) begin
			case (start_op)
				fcs_pkg::OP_PROGRAM:    cnt_q <= 21'(PROG_CYCLES - 1);
				fcs_pkg::OP_READ_PROT:  cnt_q <= 21'(RPROT_CYCLES - 1);
				default:                cnt_q <= 21'(ERASE_CYCLES - 1);
			endcase
		end else if (cnt_q != 21'h0_0000) begin
			cnt_q <= cnt_q - 21'h0_0001;
		end
	end

	assign op_done = (state_q == fcs_pkg::ST_BUSY) && (cnt_q == 21'h0_0000) && !walk_on_q;

	// ==========================================================
	// Erase walker: one byte per cycle
	assign walk_addr = {sect_base_q, walk_q[11:0]};
	assign walk_last = sect_on_q ? 14'(fcs_pkg::SECTOR_BYTES - 1) :
	                               14'(fcs_pkg::ARRAY_BYTES - 1);

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			walk_q      <= 14'h0000;
			walk_on_q   <= 1'b0;
			sect_on_q   <= 1'b0;
			sect_base_q <= 8'h00;
		end else if (start) begin
			walk_q      <= 14'h0000;
			walk_on_q   <= (start_op == fcs_pkg::OP_SECT_ERASE) ||
			               (start_op == fcs_pkg::OP_CHIP_ERASE);
			sect_on_q   <= (start_op == fcs_pkg::OP_SECT_ERASE);
			sect_base_q <= bus_i.addr[19:12];
		end else if (walk_on_q) begin
			walk_q <= walk_q + 14'h0001;
			if (walk_q == walk_last) begin
				walk_on_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Array writes
	always_ff @(posedge ref_clk_i) begin
		if (start && (start_op == fcs_pkg::OP_PROGRAM)) begin
			mem[array_index(bus_i.addr)] <= bus_i.wdata;
		end else if (walk_on_q) begin
			if (!sect_on_q) begin
				mem[walk_q] <= fcs_pkg::ERASED_BYTE;
			end else if (in_flash(walk_addr)) begin
				mem[array_index(walk_addr)] <= fcs_pkg::ERASED_BYTE;
			end
		end
	end

	// ==========================================================
	// Read protection
	// Kept through reset like the array: only a finished chip erase clears it.
	// A fresh part reads unknown protection until its first chip erase or read-protect operation.
	always_ff @(posedge ref_clk_i) begin
		if (op_done && (op_q == fcs_pkg::OP_READ_PROT)) begin
			rp_q <= 1'b1;
		end else if (op_done && (op_q == fcs_pkg::OP_CHIP_ERASE)) begin
			rp_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			serial_lock_q <= 1'b0;
		end else begin
			serial_lock_q <= rp_q && (mode_q == fcs_pkg::MODE_SERIAL);
		end
	end

	// ==========================================================
	// Toggle bit
	// Any flash read while busy flips it; the address is not compared, so a
	// poll loop on one address sees every flip
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			tog_q <= 1'b1;
		end else if (start) begin
			tog_q <= 1'b1;
		end else if (bus_i.re && in_flash(bus_i.addr) && (state_q == fcs_pkg::ST_BUSY)) begin
			tog_q <= ~tog_q;
		end
	end

	// ==========================================================
	// Read data, one cycle after the strobe
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rd_data_q <= 8'h00;
		end else if (bus_i.re) begin
			if (bus_i.addr == fcs_pkg::CTRL_ADDR) begin
				rd_data_q <= {key_q, 4'h0};
			end else if (!in_flash(bus_i.addr)) begin
				rd_data_q <= 8'h00;
			end else if (rp_q && (mode_q == fcs_pkg::MODE_PARALLEL)) begin
				rd_data_q <= fcs_pkg::ERASED_BYTE;
			end else if (state_q == fcs_pkg::ST_BUSY) begin
				rd_data_q <= mem[array_index(bus_i.addr)];
				rd_data_q[fcs_pkg::TOGGLE_BIT] <= tog_q;
			end else if (id_mode_q && (bus_i.addr == fcs_pkg::ID_MAKER_ADDR)) begin
				rd_data_q <= MAKER_CODE;
			end else if (id_mode_q && (bus_i.addr == fcs_pkg::ID_MACRO_ADDR)) begin
				rd_data_q <= MACRO_CODE;
			end else if (id_mode_q && (bus_i.addr == fcs_pkg::ID_SIZE_ADDR)) begin
				rd_data_q <= SIZE_CODE;
			end else if (id_mode_q && (bus_i.addr == fcs_pkg::ID_PROT_ADDR)) begin
				rd_data_q <= rp_q ? fcs_pkg::PROT_ON_CODE : fcs_pkg::PROT_OFF_CODE;
			end else begin
				rd_data_q <= mem[array_index(bus_i.addr)];
			end
		end
	end

	// ==========================================================
	// Busy flag
	// Registered copy of the busy state, so the pin comes straight from a flop
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= (state_d == fcs_pkg::ST_BUSY);
		end
	end

	// ==========================================================
	// Outputs
	assign rd_data_o      = rd_data_q;
	assign busy_o         = busy_q;
	assign id_mode_o      = id_mode_q;
	assign read_protect_o = rp_q;
	assign serial_lock_o  = serial_lock_q;

endmodule

// ---- rtl/fcs_pkg.sv ----
package fcs_pkg;

	// ==========================================================
	// Bus carrier
	typedef struct packed {
		logic [19:0] addr;
		logic [7:0]  wdata;
		logic        we;
		logic        re;
	} fcs_bus_s;

	// ==========================================================
	// Address map
	localparam logic [19:0] FLASH_LO_BASE   = 20'h0_4000;
	localparam logic [19:0] FLASH_LO_LAST   = 20'h0_7EFF;
	localparam logic [19:0] FLASH_TOP_BASE  = 20'hF_FF00;
	localparam logic [13:0] TOP_PAGE_INDEX  = 14'h3F00;
	localparam logic [19:0] CTRL_ADDR       = 20'h0_0FC0;
	localparam int          ARRAY_BYTES     = 16384;
	localparam int          SECTOR_BYTES    = 4096;

	// ==========================================================
	// Control register layout and values
	localparam int          KEY_LSB         = 4;
	localparam logic [3:0]  KEY_ENABLE      = 4'h3;
	localparam logic [3:0]  KEY_RESET       = 4'hC;

	// ==========================================================
	// Command cycles
	localparam logic [19:0] UNLOCK_ADDR_A   = 20'h0_4555;
	localparam logic [19:0] UNLOCK_ADDR_B   = 20'h0_4AAA;
	localparam logic [7:0]  UNLOCK_DATA_A   = 8'hAA;
	localparam logic [7:0]  UNLOCK_DATA_B   = 8'h55;
	localparam logic [7:0]  CMD_PROGRAM     = 8'hA0;
	localparam logic [7:0]  CMD_EXTEND      = 8'h80;
	localparam logic [7:0]  CMD_ID_ENTRY    = 8'h90;
	localparam logic [7:0]  CMD_ID_EXIT     = 8'hF0;
	localparam logic [7:0]  CMD_CHIP_ERASE  = 8'h10;
	localparam logic [7:0]  CMD_SECT_ERASE  = 8'h30;
	localparam logic [7:0]  CMD_READ_PROT   = 8'h60;

	// ==========================================================
	// Identification map
	localparam logic [19:0] ID_MAKER_ADDR   = 20'h0_4000;
	localparam logic [19:0] ID_MACRO_ADDR   = 20'h0_4001;
	localparam logic [19:0] ID_SIZE_ADDR    = 20'h0_4002;
	localparam logic [19:0] ID_PROT_ADDR    = 20'h0_4F7F;
	localparam logic [7:0]  SIZE_CODE_16K   = 8'h03;
	localparam logic [7:0]  PROT_OFF_CODE   = 8'hFF;
	localparam logic [7:0]  PROT_ON_CODE    = 8'h00;
	localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
	localparam int          TOGGLE_BIT      = 6;

	// ==========================================================
	// Programming modes
	localparam logic [1:0]  MODE_CPU        = 2'h0;
	localparam logic [1:0]  MODE_SERIAL     = 2'h1;
	localparam logic [1:0]  MODE_PARALLEL   = 2'h2;

	// ==========================================================
	// Operation kinds
	localparam logic [1:0]  OP_PROGRAM      = 2'h0;
	localparam logic [1:0]  OP_SECT_ERASE   = 2'h1;
	localparam logic [1:0]  OP_CHIP_ERASE   = 2'h2;
	localparam logic [1:0]  OP_READ_PROT    = 2'h3;

	// ==========================================================
	// Timing
	localparam int          CLK_PERIOD_NS   = 20;
	localparam int          PROG_TIME_NS    = 40000;
	localparam int          RPROT_TIME_NS   = 40000;
	localparam int          ERASE_TIME_NS   = 30000000;
	localparam int          PROG_CYC        = PROG_TIME_NS / CLK_PERIOD_NS;
	localparam int          RPROT_CYC       = RPROT_TIME_NS / CLK_PERIOD_NS;
	localparam int          ERASE_CYC       = ERASE_TIME_NS / CLK_PERIOD_NS;

	// ==========================================================
	// Sequencer states
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_UNL1 = 8'h02,
		ST_UNL2 = 8'h04,
		ST_PROG = 8'h08,
		ST_EXT3 = 8'h10,
		ST_EXT4 = 8'h20,
		ST_EXT5 = 8'h40,
		ST_BUSY = 8'h80
	} fcs_state_e;

endpackage

// ---- tb/fcs_seq_monitor.sv ----
`timescale 1ns/100ps
module fcs_seq_monitor #(
	parameter int ERASE_CYCLES = 20000
) (
	input wire logic              ref_clk_i,
	input wire logic              sys_rst_i,
	input wire fcs_pkg::fcs_bus_s bus_i,
	input wire logic [1:0]        prog_mode_i,
	input wire logic [7:0]        rd_data_o,
	input wire logic              busy_o,
	input wire logic              id_mode_o,
	input wire logic              read_protect_o,
	input wire logic              serial_lock_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// ==========================================
	// Toggle history and busy length
	localparam int BUSY_MAX = ((ERASE_CYCLES > 16384) ? ERASE_CYCLES : 16384) + 8;
	logic        busy_q, first_q, rd_v_q, rd_first_q, have_q, b6_q;
	logic [24:0] run_q;
	wire         in_lo = bus_i.addr >= 20'h0_4000 && bus_i.addr <= 20'h0_7EFF;
	wire         fl_rd = bus_i.re && busy_o && (in_lo || bus_i.addr >= 20'hF_FF00);
	wire         first_now = first_q || (busy_o && !busy_q);
	wire         id_rd = bus_i.re && id_mode_o && !busy_o && prog_mode_i == fcs_pkg::MODE_CPU;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			busy_q     <= 1'b0;
			first_q    <= 1'b0;
			rd_v_q     <= 1'b0;
			rd_first_q <= 1'b0;
			have_q     <= 1'b0;
			b6_q       <= 1'b0;
		end else begin
			busy_q     <= busy_o;
			rd_v_q     <= fl_rd;
			rd_first_q <= first_now;
			first_q    <= first_now && !fl_rd;
			if (busy_o && !busy_q) begin
				have_q <= 1'b0;
			end else if (rd_v_q) begin
				have_q <= 1'b1;
				b6_q   <= rd_data_o[6];
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || !busy_o)
			run_q <= '0;
		else
			run_q <= run_q + 25'd1;
	end

	// ==========================================
	// Properties
	a_busy_after_write: assert property ($rose(busy_o) |-> $past(bus_i.we))
		else $error("busy rose without a write");
	a_busy_bounded: assert property (run_q <= BUSY_MAX)
		else $error("busy lasted too long");
	a_first_toggle: assert property (rd_v_q && rd_first_q |-> rd_data_o[6])
		else $error("first poll bit not one");
	a_toggle_flip: assert property (rd_v_q && have_q && !rd_first_q |->
		rd_data_o[6] != b6_q) else $error("poll bit did not flip");
	a_ctrl_nibble: assert property (bus_i.re && bus_i.addr == fcs_pkg::CTRL_ADDR |=>
		rd_data_o[7:4] inside {4'h3, 4'hC}) else $error("bad key value read");
	a_unmapped_zero: assert property (bus_i.re && bus_i.addr < 20'h0_4000 &&
		bus_i.addr != fcs_pkg::CTRL_ADDR |=> rd_data_o == 8'h00)
		else $error("unmapped read not zero");
	a_id_size: assert property (id_rd && bus_i.addr == fcs_pkg::ID_SIZE_ADDR |=>
		rd_data_o == 8'h03) else $error("size code wrong");
	a_id_protect: assert property (id_rd && bus_i.addr == fcs_pkg::ID_PROT_ADDR |=>
		(rd_data_o == 8'hFF) == !$past(read_protect_o)) else $error("protect code wrong");
	a_protect_sticky: assert property ($fell(read_protect_o) |->
		$past(busy_o) || $past(busy_o, 2)) else $error("protect cleared outside erase");
	a_serial_lock: assert property (serial_lock_o |-> $past(read_protect_o))
		else $error("serial lock without protect");
endmodule

// ---- tb/fcs_cpu_model.sv ----
`timescale 1ns/100ps
module fcs_cpu_model (
	input  wire logic        ref_clk_i,
	input  wire logic [7:0]  rd_data_i,
	output fcs_pkg::fcs_bus_s bus_o
);
	initial bus_o = '0;

	// Write strobe stays up until the next task call or idle overwrites it
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		bus_o <= '{a, d, 1'b1, 1'b0};
	endtask

	// Released lines show the inverse, not the last value
	task automatic idle();
		@(posedge ref_clk_i);
		bus_o <= '{~bus_o.addr, ~bus_o.wdata, 1'b0, 1'b0};
	endtask

	task automatic rd(input logic [19:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		bus_o <= '{a, ~bus_o.wdata, 1'b0, 1'b1};
		@(posedge ref_clk_i);
		bus_o <= '{~a, ~bus_o.wdata, 1'b0, 1'b0};
		@(posedge ref_clk_i);
		d = rd_data_i;
	endtask

	// Poll until two reads agree before any next sequence
	task automatic poll(input logic [19:0] a, input int lim, output int n);
		logic [7:0] x;
		logic [7:0] y;
		n = 0;
		rd(a, x);
		do begin
			y = x;
			rd(a, x);
			n++;
		end while (x !== y && n < lim);
	endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
	localparam int          PC = 20;
	localparam int          EC = 17000;
	localparam logic [7:0]  MK = 8'hA5;  // Arbitrary value
	localparam logic [7:0]  MC = 8'h6B;  // Arbitrary value
	localparam logic [19:0] UA = fcs_pkg::UNLOCK_ADDR_A;
	localparam logic [19:0] UB = fcs_pkg::UNLOCK_ADDR_B;
	localparam logic [19:0] CR = fcs_pkg::CTRL_ADDR;
	logic              ref_clk_i = 1'b0;
	logic              sys_rst_i = 1'b1;
	logic [1:0]        mode = fcs_pkg::MODE_CPU;
	fcs_pkg::fcs_bus_s bus;
	logic [7:0]        rdat;
	logic [7:0]        v;
	logic [19:0]       a;
	logic [31:0]       rng = 32'h2647;
	logic              busy;
	logic              idm;
	logic              prot;
	logic              slock;
	int                mismatches = 0;
	int                comparisons = 0;
	int                cyc = 0;
	int                n;

	always #10 ref_clk_i = ~ref_clk_i;

	fcs_sequencer #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC), .RPROT_CYCLES(PC),
		.MAKER_CODE(MK), .MACRO_CODE(MC)) i_dut (.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i), .bus_i(bus), .prog_mode_i(mode), .rd_data_o(rdat),
		.busy_o(busy), .id_mode_o(idm), .read_protect_o(prot), .serial_lock_o(slock));
	fcs_cpu_model i_cpu (.ref_clk_i(ref_clk_i), .rd_data_i(rdat), .bus_o(bus));

	// ==========================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h want %h", $time, w, got, exp);
		end
	endtask

	task automatic rchk(input logic [19:0] ad, input logic [7:0] e, input string w);
		i_cpu.rd(ad, v);
		chk(v, e, w);
	endtask

	task automatic unl(input logic [7:0] c, input logic [19:0] ad);
		i_cpu.wr(UA, 8'hAA);
		i_cpu.wr(UB, 8'h55);
		i_cpu.wr(ad, c);
	endtask

	task automatic settle(input int lim);
		i_cpu.poll(UA, lim + 4, n);
		chk({7'h0, busy}, 8'h00, "busy after poll");
		chk(8'(n <= lim), 8'h01, "operation too long");
	endtask

	task automatic prog(input logic [19:0] ad, input logic [7:0] d);
		unl(8'hA0, UA);
		i_cpu.wr(ad, d);
		i_cpu.idle();
		settle(PC / 3 + 3);
	endtask

	task automatic fin(input string s);
		$display("done %s", s);
	endtask

	task automatic tally_and_finish();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 70000) begin
			mismatches++;
			$display("unexpected at %0t: run did not finish", $time);
			tally_and_finish();
		end
	end

	// ==========================================
	// Scenarios
	initial begin
		repeat (20) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		rchk(CR, 8'hC0, "key at reset");
		i_cpu.wr(20'h0_0100, 8'h5A);
		rchk(20'h0_0100, 8'h00, "unmapped");
		i_cpu.wr(CR, 8'h30);
		rchk(CR, 8'h30, "key set");
		unl(8'h80, UA);
		unl(8'h10, UA);
		i_cpu.idle();
		settle(EC / 3 + 3);
		rchk(20'h0_4000, 8'hFF, "erased low");
		rchk(20'hF_FFFF, 8'hFF, "erased top");
		fin("chip erase");
		for (int i = 0; i < 6; i++) begin
			rng = xs(rng);
			a = 20'h0_4100 + 20'(rng[13:0] % 14'h3E00);
			prog(a, rng[31:24]);
			rchk(a, rng[31:24], "random program");
		end
		prog(20'hF_FF00, 8'h5A);
		rchk(20'hF_FF00, 8'h5A, "top page");
		i_cpu.wr(CR, 8'hC0);
		prog(20'hF_FF80, 8'h12);
		rchk(20'hF_FF80, 8'hFF, "locked program");
		i_cpu.wr(CR, 8'h30);
		i_cpu.wr(UA, 8'hAA);
		i_cpu.wr(UA, 8'h55);
		i_cpu.wr(UA, 8'hA0);
		i_cpu.wr(20'hF_FF81, 8'h77);
		i_cpu.idle();
		rchk(20'hF_FF81, 8'hFF, "abandoned sequence");
		unl(8'hA0, UA);
		i_cpu.wr(20'hF_FF82, 8'h11);
		prog(20'hF_FF83, 8'h22);
		rchk(20'hF_FF82, 8'h11, "first program");
		rchk(20'hF_FF83, 8'hFF, "program while busy");
		fin("program");
		unl(8'h90, UA);
		i_cpu.idle();
		rchk(20'h0_4000, MK, "maker");
		chk({7'h0, idm}, 8'h01, "id mode");
		rchk(20'h0_4001, MC, "macro");
		rchk(20'h0_4002, 8'h03, "size");
		rchk(20'h0_4F7F, 8'hFF, "unprotected");
		unl(8'hF0, UA);
		i_cpu.idle();
		rchk(20'h0_4002, 8'hFF, "array after exit");
		fin("identification");
		unl(8'h80, UA);
		unl(8'h60, UA);
		i_cpu.idle();
		settle(PC / 3 + 3);
		chk({7'h0, prot}, 8'h01, "protect set");
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		chk({7'h0, prot}, 8'h01, "protect kept over reset");
		rchk(CR, 8'hC0, "key after reset");
		i_cpu.wr(CR, 8'h30);
		unl(8'h90, UA);
		i_cpu.idle();
		rchk(20'h0_4F7F, 8'h00, "protected");
		unl(8'hF0, UA);
		i_cpu.idle();
		mode <= fcs_pkg::MODE_SERIAL;
		repeat (8) @(posedge ref_clk_i);
		chk({7'h0, slock}, 8'h01, "serial lock");
		mode <= fcs_pkg::MODE_PARALLEL;
		repeat (8) @(posedge ref_clk_i);
		rchk(20'hF_FF00, 8'hFF, "parallel read");
		unl(8'h80, UA);
		unl(8'h30, 20'hF_FF00);
		i_cpu.idle();
		mode <= fcs_pkg::MODE_CPU;
		repeat (8) @(posedge ref_clk_i);
		chk({7'h0, busy}, 8'h00, "parallel erase");
		rchk(20'hF_FF00, 8'h5A, "sector kept");
		prog(20'h0_5123, 8'h3C);
		unl(8'h80, UA);
		unl(8'h30, 20'h0_5ABC);
		i_cpu.idle();
		settle(EC / 3 + 3);
		rchk(20'h0_5123, 8'hFF, "sector erased");
		rchk(20'hF_FF00, 8'h5A, "other sector");
		unl(8'h80, UA);
		unl(8'h10, UA);
		i_cpu.idle();
		settle(EC / 3 + 3);
		chk({7'h0, prot}, 8'h00, "protect cleared");
		rchk(20'hF_FF00, 8'hFF, "top erased");
		fin("protect");
		tally_and_finish();
	end
endmodule

bind fcs_sequencer fcs_seq_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) i_mon (
	.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i),
	.prog_mode_i(prog_mode_i), .rd_data_o(rd_data_o), .busy_o(busy_o),
	.id_mode_o(id_mode_o), .read_protect_o(read_protect_o),
	.serial_lock_o(serial_lock_o));
